/* File: rtl/hcsi_host_regs.sv */
// host configuration registers, sleep ports and sequencer index
`timescale 1ns/100ps
//
// Behaviour
// - base and interrupt config registers exist and act only in pci mode
// - base bits 31:24 hold the 16-Mbyte display window; 23:1 reserved
// - base bit 0 reports space type, 0 memory, 1 i/o; resets 0
// - space bit writable on pci, read-only on local bus
// - memory cycles claimed in pci mode only while command memory enable is 1; local bus ignores the enable
// - interrupt pin field 15:8 reads 01h, read-only
// - interrupt line 7:0 is read/write scratch, resets zero
// - port ALTERNATE_SLEEP_CONTROL sleep register active only if strap pulled up at reset
// - without the strap, port 3C3 is the sleep register
// - strap status bit 5 reads 1 when the strap pull-up is present
// - sleep select 0: ignore memory and i/o except the active sleep port (ALTERNATE_SLEEP_CONTROL or 3C3), bios still served
// - sleep select 1, the reset value: device responds normally
// - port 3C4 holds 6-bit index choosing the register at 3C5
// - index above 5 selects the extension register set
// - index 10h or 11h: bits 4:0 index, bits 7:5 fine position
// - vertical position index: bits 7:5 set fine vertical offset
// - horizontal position index: bits 7:5 set fine horizontal offset
// - cursor extension bit 0 is cursor fine horizontal msb
// - icon extension bit 6 is icon fine horizontal msb

module hcsi_host_regs
  import hcsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pciMode,
  input wire logic sleepPortStrapPin,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  output logic [31:0] cfgReadData,
  output logic cfgReadValid,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWriteData,
  output logic [7:0] ioReadData,
  output logic ioReadValid,
  output logic ioClaim,
  input wire logic memCycle,
  input wire logic [31:0] memAddr,
  output logic memClaim,
  input wire logic biosCycle,
  output logic biosClaim,
  output logic deviceAwake,
  output logic [5:0] seqIndex,
  output logic extSelect,
  output logic seqDataWrite,
  output logic seqDataRead,
  output logic [3:0] cursorFineHoriz,
  output logic [3:0] iconFineHoriz,
  output logic [2:0] fineVert
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic cmdIoEnable;
  logic cmdMemEnable;
  logic [7:0] memBase;
  logic memSpace;
  logic [7:0] intLine;
  logic altSleepSelect;
  logic vgaSleepSelect;
  logic [2:0] fineHorizLow;
  logic cursorExtBit;
  logic iconExtBit;
  logic strapped;
  logic strapTaken;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  hcsi_strap_latch strapLatch (
    .clk(clk),
    .reset(reset),
    .strapPin(sleepPortStrapPin),
    .strapped(strapped),
    .strapTaken(strapTaken)
  );

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  // config space decodes only in pci mode; reads elsewhere are answered with zero
  wire cfgLive = pciMode;
  wire cfgWrLive = cfgWrite && cfgLive;
  wire hitCommand = (cfgAddr == CFG_COMMAND_OFFSET);
  wire hitMemBase = (cfgAddr == CFG_MEM_BASE_OFFSET);
  wire hitIntRegs = (cfgAddr == CFG_INT_PIN_LINE_OFFSET);
  wire wrCommand = cfgWrLive && hitCommand && cfgByteEn[0];
  wire wrBaseHigh = cfgWrLive && hitMemBase && cfgByteEn[3];
  wire wrSpace = cfgWrLive && hitMemBase && cfgByteEn[0] && pciMode;
  wire wrIntLine = cfgWrLive && hitIntRegs && cfgByteEn[0];

  // read images, reserved bits as zero
  wire [31:0] cmdImage = {30'h0, cmdMemEnable, cmdIoEnable};
  wire [31:0] baseImage = {memBase, 23'h0, memSpace};
  wire [31:0] intImage = {16'h0, INT_PIN_VALUE, intLine};
  wire [31:0] cfgImage = !cfgLive ? 32'h0000_0000 :
                         hitCommand ? cmdImage :
                         hitMemBase ? baseImage :
                         hitIntRegs ? intImage : 32'h0000_0000;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdIoEnable <= CMD_IO_ENABLE_RESET;
      cmdMemEnable <= CMD_MEM_ENABLE_RESET;
    end else if (wrCommand) begin
      cmdIoEnable <= cfgWriteData[CMD_IO_ENABLE_BIT];
      cmdMemEnable <= cfgWriteData[CMD_MEM_ENABLE_BIT];
    end
  end

  // base address upper field
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      memBase <= MEM_BASE_RESET;
    end else if (wrBaseHigh) begin
      memBase <= cfgWriteData[MEM_BASE_MSB:MEM_BASE_LSB];
    end
  end

  // space type indicator
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      memSpace <= MEM_SPACE_RESET;
    end else if (wrSpace) begin
      memSpace <= cfgWriteData[MEM_SPACE_BIT];
    end
  end

  // interrupt line scratch byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intLine <= INT_LINE_RESET;
    end else if (wrIntLine) begin
      intLine <= cfgWriteData[INT_LINE_LSB +: 8];
    end
  end

  // config read answer, one cycle later
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgReadData <= 32'h0000_0000;
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        cfgReadData <= cfgImage;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  // the strap picks which port holds the sleep bit
  wire altSleepPort = strapTaken && strapped;
  wire awake = altSleepPort ? altSleepSelect : vgaSleepSelect;

  // i/o enable is forced in local-bus mode
  wire ioEnabled = !pciMode || cmdIoEnable;
  wire memEnabled = !pciMode || cmdMemEnable;

  // port hits
  wire hitAltSleep = (ioAddr == PORT_ALT_SLEEP) && altSleepPort;
  wire hitVgaSleep = (ioAddr == PORT_VGA_SLEEP) && !altSleepPort;
  wire hitSeqIndex = (ioAddr == PORT_SEQ_INDEX);
  wire hitSeqData = (ioAddr == PORT_SEQ_DATA);

  // asleep, only the port holding the sleep bit answers, else the device could never wake
  wire liveAltSleep = ioEnabled && hitAltSleep;
  wire liveVgaSleep = ioEnabled && hitVgaSleep;
  wire liveNormal = ioEnabled && awake && (hitSeqIndex || hitSeqData);
  wire ioHit = liveAltSleep || liveVgaSleep || liveNormal;

  wire wrAltSleep = ioWrite && liveAltSleep;
  wire wrVgaSleep = ioWrite && liveVgaSleep;
  wire wrSeqIndex = ioWrite && liveNormal && hitSeqIndex;
  wire wrSeqData = ioWrite && liveNormal && hitSeqData;
  wire rdSeqData = ioRead && liveNormal && hitSeqData;

  // alternate sleep register bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      altSleepSelect <= SLEEP_ENABLE_RESET;
    end else if (wrAltSleep) begin
      altSleepSelect <= ioWriteData[ALT_SLEEP_BIT];
    end
  end

  // standard sleep register bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vgaSleepSelect <= SLEEP_ENABLE_RESET;
    end else if (wrVgaSleep) begin
      vgaSleepSelect <= ioWriteData[VGA_SLEEP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // sequencer index decode
  // ----------------------------------------------------------------
  // index 10h and 11h use five bits and carry the fine position above
  wire isHorizIdx = (ioWriteData[4:0] == IDX_HORIZ_FINE);
  wire isVertIdx = (ioWriteData[4:0] == IDX_VERT_FINE);
  wire isFineIdx = isHorizIdx || isVertIdx;
  wire [5:0] next_seqIndex = isFineIdx ? {1'b0, ioWriteData[4:0]} : ioWriteData[5:0];
  wire [2:0] writtenFine = ioWriteData[7:5];

  // extension index write strobes
  wire wrIconExt = wrSeqData && (seqIndex == IDX_ICON_EXT);
  wire wrCursorExt = wrSeqData && (seqIndex == IDX_CURSOR_EXT);

  // index register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seqIndex <= SEQ_INDEX_RESET;
    end else if (wrSeqIndex) begin
      seqIndex <= next_seqIndex;
    end
  end

  // fine horizontal offset, low three bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fineHorizLow <= FINE_POS_RESET;
    end else if (wrSeqIndex && isHorizIdx) begin
      fineHorizLow <= writtenFine;
    end
  end

  // fine vertical offset in scanlines
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fineVert <= FINE_POS_RESET;
    end else if (wrSeqIndex && isVertIdx) begin
      fineVert <= writtenFine;
    end
  end

  // fourth horizontal bits for cursor and icon
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cursorExtBit <= 1'b0;
      iconExtBit <= 1'b0;
    end else begin
      if (wrCursorExt) begin
        cursorExtBit <= ioWriteData[CURSOR_EXT_BIT];
      end
      if (wrIconExt) begin
        iconExtBit <= ioWriteData[ICON_EXT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // i/o read data
  // ----------------------------------------------------------------
  // index port shows the last fine bits over the index
  wire [2:0] lastFine = (seqIndex[4:0] == IDX_VERT_FINE) ? fineVert : fineHorizLow;
  wire [7:0] idxImage = (seqIndex == {1'b0, IDX_HORIZ_FINE}) || (seqIndex == {1'b0, IDX_VERT_FINE}) ?
                        {lastFine, seqIndex[4:0]} : {2'b00, seqIndex};
  wire [7:0] strapImage = {2'b00, strapped, 5'h00};
  wire [7:0] iconImage = {1'b0, iconExtBit, 6'h00};
  wire [7:0] cursorImage = {7'h00, cursorExtBit};
  wire [7:0] dataImage = (seqIndex == IDX_STRAP_STATUS) ? strapImage :
                         (seqIndex == IDX_ICON_EXT) ? iconImage :
                         (seqIndex == IDX_CURSOR_EXT) ? cursorImage : 8'h00;
  wire [7:0] altImage = {4'h0, altSleepSelect, 3'h0};
  wire [7:0] vgaImage = {7'h00, vgaSleepSelect};
  wire [7:0] ioImage = hitSeqIndex ? idxImage :
                       hitSeqData ? dataImage :
                       hitAltSleep ? altImage :
                       hitVgaSleep ? vgaImage : 8'h00;

  // i/o read answer, one cycle later, zero when unclaimed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ioReadData <= 8'h00;
      ioReadValid <= 1'b0;
    end else begin
      ioReadValid <= ioRead;
      if (ioRead) begin
        ioReadData <= ioHit ? ioImage : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory decode and outputs
  // ----------------------------------------------------------------
  // pci mode compares the window base; local bus is decoded outside
  wire baseMatch = (memAddr[MEM_BASE_MSB:MEM_BASE_LSB] == memBase);
  wire memHit = pciMode ? (baseMatch && !memSpace) : 1'b1;
  assign memClaim = memCycle && memHit && memEnabled && awake;

  // handshake strobes and decodes
  assign ioClaim = (ioWrite || ioRead) && ioHit;
  assign biosClaim = biosCycle;
  assign deviceAwake = awake;
  assign extSelect = (seqIndex > SEQ_LAST_STANDARD);
  assign seqDataWrite = wrSeqData;
  assign seqDataRead = rdSeqData;
  assign cursorFineHoriz = {cursorExtBit, fineHorizLow};
  assign iconFineHoriz = {iconExtBit, fineHorizLow};

endmodule : hcsi_host_regs

/* File: rtl/hcsi_pkg.sv */
// constants shared by the host configuration and sequencer index logic
package hcsi_pkg;

  // ----------------------------------------------------------------
  // configuration space offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_COMMAND_OFFSET = 8'h04;
  localparam logic [7:0] CFG_MEM_BASE_OFFSET = 8'h10;
  localparam logic [7:0] CFG_INT_PIN_LINE_OFFSET = 8'h3C;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_IO_ENABLE_BIT = 0;
  localparam int CMD_MEM_ENABLE_BIT = 1;
  localparam logic CMD_IO_ENABLE_RESET = 1'b0;
  localparam logic CMD_MEM_ENABLE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // display memory base register fields
  // ----------------------------------------------------------------
  localparam int MEM_BASE_MSB = 31;
  localparam int MEM_BASE_LSB = 24;
  localparam int MEM_SPACE_BIT = 0;
  localparam logic [7:0] MEM_BASE_RESET = 8'h00;
  localparam logic MEM_SPACE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // interrupt pin and line fields
  // ----------------------------------------------------------------
  localparam int INT_PIN_LSB = 8;
  localparam int INT_LINE_LSB = 0;
  localparam logic [7:0] INT_PIN_VALUE = 8'h01;
  localparam logic [7:0] INT_LINE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // i/o port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_VGA_SLEEP = 16'h03C3;
  localparam logic [15:0] PORT_SEQ_INDEX = 16'h03C4;
  localparam logic [15:0] PORT_SEQ_DATA = 16'h03C5;
  localparam logic [15:0] PORT_ALT_SLEEP = 16'h46E8;

  // ----------------------------------------------------------------
  // sleep register fields
  // ----------------------------------------------------------------
  localparam int ALT_SLEEP_BIT = 3;
  localparam int VGA_SLEEP_BIT = 0;
  localparam logic SLEEP_ENABLE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // sequencer index fields and extension indices
  // ----------------------------------------------------------------
  localparam logic [5:0] SEQ_INDEX_RESET = 6'h04;
  localparam logic [2:0] FINE_POS_RESET = 3'h0;
  localparam logic [5:0] SEQ_LAST_STANDARD = 6'h05;
  localparam logic [4:0] IDX_HORIZ_FINE = 5'h10;
  localparam logic [4:0] IDX_VERT_FINE = 5'h11;
  localparam logic [5:0] IDX_STRAP_STATUS = 6'h22;
  localparam logic [5:0] IDX_ICON_EXT = 6'h2A;
  localparam logic [5:0] IDX_CURSOR_EXT = 6'h2E;
  localparam int STRAP_STATUS_BIT = 5;
  localparam int ICON_EXT_BIT = 6;
  localparam int CURSOR_EXT_BIT = 0;

endpackage : hcsi_pkg

/* File: rtl/hcsi_strap_latch.sv */
// catches the sleep-port strap level once reset has been released
`timescale 1ns/100ps

module hcsi_strap_latch
  import hcsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic strapPin,
  output logic strapped,
  output logic strapTaken
);

  // ----------------------------------------------------------------
  // capture on the first edge after release
  // ----------------------------------------------------------------
  // the pin is read by a clocked process only, never under the reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapped <= 1'b0;
      strapTaken <= 1'b0;
    end else if (!strapTaken) begin
      strapped <= strapPin;
      strapTaken <= 1'b1;
    end
  end

endmodule : hcsi_strap_latch

/* File: verif/hcsi_host_regs_monitor.sv */
// checker for the host register block, bound to its ports
`timescale 1ns/100ps

module hcsi_host_regs_monitor
  import hcsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pciMode,
  input wire logic cfgRead,
  input wire logic cfgReadValid,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWriteData,
  input wire logic ioClaim,
  input wire logic memCycle,
  input wire logic memClaim,
  input wire logic biosCycle,
  input wire logic biosClaim,
  input wire logic deviceAwake,
  input wire logic [5:0] seqIndex,
  input wire logic extSelect,
  input wire logic seqDataWrite,
  input wire logic seqDataRead,
  input wire logic [3:0] cursorFineHoriz,
  input wire logic [2:0] fineVert
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // helper terms for index and alternate sleep port writes
  wire logic idxWr = ioWrite && ioClaim && ioAddr == PORT_SEQ_INDEX;
  wire logic altWr = ioWrite && ioClaim && ioAddr == PORT_ALT_SLEEP;

  read_answer_a: assert property (cfgRead && pciMode |=> cfgReadValid)
    else $error("config read not answered");
  bios_served_a: assert property (biosClaim == biosCycle)
    else $error("bios cycle not answered");
  ext_select_a: assert property (extSelect == (seqIndex > 6'h05))
    else $error("extension select wrong");
  mem_sleep_a: assert property (memClaim |-> memCycle && deviceAwake)
    else $error("memory claimed while asleep");
  io_sleep_a: assert property (ioClaim && !deviceAwake |->
    ioAddr == PORT_ALT_SLEEP || ioAddr == PORT_VGA_SLEEP) else $error("port claimed while asleep");
  data_strobe_a: assert property (seqDataWrite == (ioWrite && ioClaim && ioAddr == PORT_SEQ_DATA))
    else $error("data port strobe wrong");
  data_read_a: assert property (seqDataRead == (ioRead && ioClaim && ioAddr == PORT_SEQ_DATA))
    else $error("data port read strobe wrong");
  fine_horiz_a: assert property (idxWr && ioWriteData[4:0] == 5'h10 |=>
    seqIndex == 6'h10 && cursorFineHoriz[2:0] == $past(ioWriteData[7:5])) else $error("horizontal fine wrong");
  fine_vert_a: assert property (idxWr && ioWriteData[4:0] == 5'h11 |=>
    seqIndex == 6'h11 && fineVert == $past(ioWriteData[7:5])) else $error("vertical fine wrong");
  sleep_write_a: assert property (altWr |=> deviceAwake == $past(ioWriteData[3]))
    else $error("sleep select not taken");
endmodule : hcsi_host_regs_monitor

bind hcsi_host_regs hcsi_host_regs_monitor hcsi_host_regs_monitor_i (.*);

/* File: verif/hcsi_host_model.sv */
// host bridge model driving config, i/o, memory and bios cycles
`timescale 1ns/100ps

module hcsi_host_model (
  input wire logic clk,
  output logic cfgWrite,
  output logic cfgRead,
  output logic [7:0] cfgAddr,
  output logic [3:0] cfgByteEn,
  output logic [31:0] cfgWriteData,
  input wire logic [31:0] cfgReadData,
  input wire logic cfgReadValid,
  output logic ioWrite,
  output logic ioRead,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWriteData,
  input wire logic [7:0] ioReadData,
  input wire logic ioReadValid,
  input wire logic ioClaim,
  output logic memCycle,
  output logic [31:0] memAddr,
  input wire logic memClaim,
  output logic biosCycle,
  input wire logic biosClaim
);
  // ----------------------------------------------------------------
  // bus cycles; released lines flip so stale values never match
  // ----------------------------------------------------------------
  initial begin
    {cfgWrite, cfgRead, ioWrite, ioRead, memCycle, biosCycle} = 6'h00;
    {cfgAddr, cfgByteEn, cfgWriteData} = 44'h0;
    {ioAddr, ioWriteData, memAddr} = 56'h0;
  end

  // one config cycle, read data taken with its valid pulse
  task automatic cfg(input logic wr, input logic [3:0] be, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge clk);
    cfgWrite = wr;
    cfgRead = !wr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWriteData = d;
    @(negedge clk);
    q = (cfgReadValid === 1'b1) ? cfgReadData : 'x;
    {cfgWrite, cfgRead} = 2'h0;
    cfgAddr = ~a;
    cfgWriteData = ~d;
  endtask : cfg

  // one i/o cycle, claim seen in the request cycle
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic c, output logic [7:0] q);
    @(negedge clk);
    ioWrite = wr;
    ioRead = !wr;
    ioAddr = a;
    ioWriteData = d;
    #1 c = ioClaim;
    @(negedge clk);
    q = (ioReadValid === 1'b1) ? ioReadData : 'x;
    {ioWrite, ioRead} = 2'h0;
    ioAddr = ~a;
    ioWriteData = ~d;
  endtask : io

  // one memory or bios cycle, returns the claim
  task automatic mem(input logic b, input logic [31:0] a, output logic c);
    @(negedge clk);
    memCycle = !b;
    biosCycle = b;
    memAddr = a;
    #1 c = b ? biosClaim : memClaim;
    @(negedge clk);
    {memCycle, biosCycle} = 2'h0;
    memAddr = ~a;
  endtask : mem
endmodule : hcsi_host_model

/* File: verif/hcsi_host_regs_tb_top.sv */
// testbench for the host register block
`timescale 1ns/100ps

module hcsi_host_regs_tb_top;
  logic clk, reset, pciMode, sleepPortStrapPin, c;
  logic cfgWrite, cfgRead, cfgReadValid, ioWrite, ioRead, ioReadValid, ioClaim;
  logic memCycle, memClaim, biosCycle, biosClaim, deviceAwake, extSelect, seqDataWrite, seqDataRead;
  logic [7:0] cfgAddr, ioWriteData, ioReadData, q8;
  logic [3:0] cfgByteEn, cursorFineHoriz, iconFineHoriz;
  logic [31:0] cfgWriteData, cfgReadData, memAddr, q32;
  logic [15:0] ioAddr;
  logic [5:0] seqIndex;
  logic [2:0] fineVert;
  int errCount, checked;

  hcsi_host_regs hcsi_host_regs_i (.*);
  hcsi_host_model hcsi_host_model_i (.*);

  // ----------------------------------------------------------------
  // clock, compare and access tasks
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : giveVerdict

  task automatic cfgWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    hcsi_host_model_i.cfg(1'b1, be, a, d, q32);
  endtask : cfgWr

  task automatic cfgRd(input logic [7:0] a, input logic [31:0] e);
    hcsi_host_model_i.cfg(1'b0, 4'hF, a, 32'h0, q32);
    check("config read", e, q32);
  endtask : cfgRd

  task automatic ioWr(input logic [15:0] a, input logic [7:0] d, input logic e);
    hcsi_host_model_i.io(1'b1, a, d, c, q8);
    check("port claim", e, c);
  endtask : ioWr

  task automatic ioRd(input logic [15:0] a, input logic [7:0] e);
    hcsi_host_model_i.io(1'b0, a, 8'h0, c, q8);
    check("port read", e, q8);
  endtask : ioRd

  task automatic memChk(input logic b, input logic [31:0] a, input logic e);
    hcsi_host_model_i.mem(b, a, c);
    check("memory claim", e, c);
  endtask : memChk

  task automatic doReset(input logic s, input logic m);
    @(negedge clk);
    reset = 1'b1;
    sleepPortStrapPin = s;
    pciMode = m;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask : doReset

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    giveVerdict();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    pciMode = 1'b1;
    sleepPortStrapPin = 1'b1;
    doReset(1'b1, 1'b1);
    cfgRd(8'h10, 32'h00000000);
    cfgRd(8'h3C, 32'h00000100);
    cfgWr(8'h10, 32'hFFFFFFFF, 4'hF);
    cfgRd(8'h10, 32'hFF000001);
    cfgWr(8'h3C, 32'hFFFFFFFF, 4'hF);
    cfgRd(8'h3C, 32'h000001FF);
    cfgWr(8'h04, 32'h00000003, 4'hF);
    memChk(1'b0, 32'hFF000000, 1'b0);
    cfgWr(8'h10, 32'hA5000000, 4'h8);
    cfgRd(8'h10, 32'hA5000001);
    cfgWr(8'h10, 32'hA5000000, 4'h1);
    memChk(1'b0, 32'hA5123456, 1'b1);
    memChk(1'b0, 32'hA6000000, 1'b0);
    cfgWr(8'h04, 32'h00000001, 4'hF);
    memChk(1'b0, 32'hA5000000, 1'b0);
    cfgWr(8'h04, 32'h00000003, 4'hF);
    ioRd(16'h03C4, 8'h04);
    ioRd(16'h46E8, 8'h08);
    $display("config test done");
    ioWr(16'h03C3, 8'h00, 1'b0);
    ioWr(16'h03C4, 8'h22, 1'b1);
    ioRd(16'h03C5, 8'h20);
    ioWr(16'h46E8, 8'h00, 1'b1);
    check("awake", 1'b0, deviceAwake);
    memChk(1'b0, 32'hA5000000, 1'b0);
    memChk(1'b1, 32'h000C0000, 1'b1);
    ioWr(16'h03C4, 8'h05, 1'b0);
    ioWr(16'h46E8, 8'h08, 1'b1);
    check("awake", 1'b1, deviceAwake);
    memChk(1'b0, 32'hA5000000, 1'b1);
    $display("sleep test done");
    ioWr(16'h03C4, 8'hF0, 1'b1);
    check("index", 6'h10, seqIndex);
    ioRd(16'h03C4, 8'hF0);
    ioWr(16'h03C4, 8'hB1, 1'b1);
    check("vertical fine", 3'h5, fineVert);
    ioWr(16'h03C4, 8'h05, 1'b1);
    check("extension select", 1'b0, extSelect);
    ioWr(16'h03C4, 8'h06, 1'b1);
    check("extension select", 1'b1, extSelect);
    ioWr(16'h03C4, 8'h2E, 1'b1);
    ioWr(16'h03C5, 8'h01, 1'b1);
    check("cursor fine", 4'hF, cursorFineHoriz);
    ioWr(16'h03C4, 8'h2A, 1'b1);
    ioWr(16'h03C5, 8'h40, 1'b1);
    check("icon fine", 4'hF, iconFineHoriz);
    ioRd(16'h03C5, 8'h40);
    $display("index test done");
    @(negedge clk);
    pciMode = 1'b0;
    cfgWr(8'h3C, 32'h00000000, 4'hF);
    cfgRd(8'h3C, 32'h00000000);
    @(negedge clk);
    pciMode = 1'b1;
    cfgRd(8'h3C, 32'h000001FF);
    $display("mode test done");
    doReset(1'b0, 1'b0);
    ioRd(16'h03C4, 8'h04);
    ioWr(16'h46E8, 8'h00, 1'b0);
    ioWr(16'h03C4, 8'h22, 1'b1);
    ioRd(16'h03C5, 8'h00);
    ioWr(16'h03C3, 8'h00, 1'b1);
    check("awake", 1'b0, deviceAwake);
    ioWr(16'h03C4, 8'h05, 1'b0);
    ioWr(16'h03C3, 8'h01, 1'b1);
    check("awake", 1'b1, deviceAwake);
    $display("strap test done");
    giveVerdict();
  end
endmodule : hcsi_host_regs_tb_top
